/* src/isa_attr_pkg.sv */
package isa_attr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register shape
   localparam int REG_W   = 64;
   localparam int FIELD_W = 4;

   // Field positions (low bit of each four-bit field)
   localparam int KECCAK_LSB    = 32;
   localparam int RND_MAC_LSB   = 28;
   localparam int TXMEM_LSB     = 24;
   localparam int ATOMIC_LSB    = 20;
   localparam int CHECKSUM_LSB  = 16;
   localparam int HASH_TWO_LSB  = 12;
   localparam int HASH_ONE_LSB  = 8;
   localparam int CIPHER_LSB    = 4;
   localparam int RESERVED_LSB  = 0;

   // Field values
   localparam logic [3:0] FIELD_NONE       = 4'h0;
   localparam logic [3:0] KECCAK_ON        = 4'h1;
   localparam logic [3:0] RND_MAC_VALUE    = 4'h1;
   localparam logic [3:0] TXMEM_VALUE      = 4'h0;
   localparam logic [3:0] ATOMIC_VALUE     = 4'h2;
   localparam logic [3:0] CHECKSUM_VALUE   = 4'h1;
   localparam logic [3:0] HASH_TWO_ON      = 4'h2;
   localparam logic [3:0] HASH_ONE_ON      = 4'h1;
   localparam logic [3:0] CIPHER_ON        = 4'h2;
   localparam logic [3:0] RESERVED_VALUE   = 4'h0;

   // System register selector
   localparam logic [1:0] SEL_OP0 = 2'h3;
   localparam logic [2:0] SEL_OP1 = 3'h0;
   localparam logic [3:0] SEL_CRN = 4'h0;
   localparam logic [3:0] SEL_CRM = 4'h6;
   localparam logic [2:0] SEL_OP2 = 3'h0;

   // Trap syndrome class
   localparam logic [5:0] SYSREG_TRAP_CLASS = 6'h18;

   // Privilege levels
   localparam logic [1:0] USER_PRIVILEGE_LEVEL       = 2'h0;
   localparam logic [1:0] KERNEL_PRIVILEGE_LEVEL     = 2'h1;
   localparam logic [1:0] HYPERVISOR_PRIVILEGE_LEVEL = 2'h2;
   localparam logic [1:0] MONITOR_PRIVILEGE_LEVEL    = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Read request from the core
   typedef struct packed {
      logic       valid;
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
      logic [1:0] current_privilege_level;
      logic       hyp_enabled;
      logic       hypervisor_general_trap_bit;
      logic       hypervisor_id_trap_bit;
   } read_req_t;

   // Answer to the core
   typedef struct packed {
      logic                 hit;
      logic                 data_valid;
      logic [REG_W-1:0]     data;
      logic                 trap;
      logic [1:0]           trap_level;
      logic [5:0]           trap_class;
   } read_rsp_t;

endpackage

/* src/isa_feature_id_register.sv */
// Behaviour
// [RL1] The keccak field in 35:32 reads 0 without build_parameter_a and 1 with it.
// [RL2] Build_parameter_a counts as present only if the build parameter is set and disable is low at reset.
// [RL3] The rounding-doubling multiply field in 31:28 always reads 1.
// [RL4] The transactional-memory field in 27:24 always reads 0.
// [RL5] The atomic field in 23:20 always reads 2.
// [RL6] The checksum field in 19:16 always reads 1 whatever the build_parameter_a setting.
// [RL7] The hash-two field in 15:12 reads 0 without build_parameter_a and 2 with it.
// [RL8] The hash-one field in 11:8 reads 0 without build_parameter_a and 1 with it.
// [RL9] The cipher field in 7:4 reads 0 without build_parameter_a and 2 with it.
// [RL10] The register is selected by op0 3, op1 0, CRn 0, CRm 6, op2 0.
// [RL11] A user-level read traps with class 0x18 to hypervisor if enabled and general-trap set, else kernel.
// [RL12] A kernel read traps to hypervisor with class 0x18 if enabled and id-trap set, else returns data.
// [RL13] Hypervisor and monitor reads always return the value.
// [RL14] Bits 3:0 always read zero.
// [RL15] Fields stay fixed after reset with no write path.
module isa_feature_id_register #(
   parameter bit BUILD_PARAMETER_A = 1'b1
) (
   // Clock and reset
   input  wire logic                    REF_CLK_IN,
   input  wire logic                    RESET_N_IN,
   // Strap sampled at reset
   input  wire logic                    BUILD_PARAMETER_A_DISABLE_INPUT_IN,
   // Read request and answer
   input  wire isa_attr_pkg::read_req_t READ_REQ_IN,
   output isa_attr_pkg::read_rsp_t      READ_RSP_OUT
);
   import isa_attr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flops
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strap synchroniser; the pin is asynchronous to the core clock.
   // No reset: it must keep sampling the pin while reset is held
   logic dis_meta;
   logic dis_sync;

   always_ff @(posedge REF_CLK_IN) begin
      dis_meta <= BUILD_PARAMETER_A_DISABLE_INPUT_IN;
      dis_sync <= dis_meta;
   end

   // Capture the strap while internal reset is held; frozen once released,
   // so a later toggle of the pin cannot change what software sees.
   // No reset here either, else the capture would be cleared for the whole
   // time the strap is meant to be taken
   logic build_parameter_a_on;
   logic next_build_parameter_a_on;

   assign next_build_parameter_a_on = rst_n ? build_parameter_a_on : (BUILD_PARAMETER_A && !dis_sync); // RL2 RL15

   always_ff @(posedge REF_CLK_IN) begin
      build_parameter_a_on <= next_build_parameter_a_on;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field assembly
   function automatic logic [3:0] pick(input logic on, input logic [3:0] val);
      pick = on ? val : FIELD_NONE;
   endfunction

   logic [REG_W-1:0] reg_value;

   always_comb begin
      reg_value = '0;
      reg_value[KECCAK_LSB   +: FIELD_W] = pick(build_parameter_a_on, KECCAK_ON);   // RL1
      reg_value[RND_MAC_LSB  +: FIELD_W] = RND_MAC_VALUE;                // RL3
      reg_value[TXMEM_LSB    +: FIELD_W] = TXMEM_VALUE;                  // RL4
      reg_value[ATOMIC_LSB   +: FIELD_W] = ATOMIC_VALUE;                 // RL5
      reg_value[CHECKSUM_LSB +: FIELD_W] = CHECKSUM_VALUE;               // RL6
      reg_value[HASH_TWO_LSB +: FIELD_W] = pick(build_parameter_a_on, HASH_TWO_ON); // RL7
      reg_value[HASH_ONE_LSB +: FIELD_W] = pick(build_parameter_a_on, HASH_ONE_ON); // RL8
      reg_value[CIPHER_LSB   +: FIELD_W] = pick(build_parameter_a_on, CIPHER_ON);   // RL9
      reg_value[RESERVED_LSB +: FIELD_W] = RESERVED_VALUE;               // RL14
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decode and privilege check
   wire sel_hit = READ_REQ_IN.valid
                  && READ_REQ_IN.op0 == SEL_OP0 && READ_REQ_IN.op1 == SEL_OP1
                  && READ_REQ_IN.crn == SEL_CRN && READ_REQ_IN.crm == SEL_CRM
                  && READ_REQ_IN.op2 == SEL_OP2; // RL10
   wire lvl_user   = READ_REQ_IN.current_privilege_level == USER_PRIVILEGE_LEVEL;
   wire lvl_kernel = READ_REQ_IN.current_privilege_level == KERNEL_PRIVILEGE_LEVEL;
   wire user_to_hyp = READ_REQ_IN.hyp_enabled
                      && READ_REQ_IN.hypervisor_general_trap_bit; // RL11
   wire kern_trap   = READ_REQ_IN.hyp_enabled
                      && READ_REQ_IN.hypervisor_id_trap_bit; // RL12
   wire do_trap  = sel_hit && (lvl_user || (lvl_kernel && kern_trap)); // RL11 RL12 RL13
   wire do_read  = sel_hit && !do_trap; // RL13
   wire [1:0] trap_to = (lvl_user && !user_to_hyp) ? KERNEL_PRIVILEGE_LEVEL
                                                    : HYPERVISOR_PRIVILEGE_LEVEL;

   // Answer registered one cycle after the request; data only on a clean read
   read_rsp_t rsp;
   read_rsp_t next_rsp;

   always_comb begin
      next_rsp            = '0;
      next_rsp.hit        = sel_hit;
      next_rsp.data_valid = do_read;
      next_rsp.data       = do_read ? reg_value : '0;
      next_rsp.trap       = do_trap;
      next_rsp.trap_level = do_trap ? trap_to : USER_PRIVILEGE_LEVEL;
      next_rsp.trap_class = do_trap ? SYSREG_TRAP_CLASS : 6'h00;
   end

   always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         rsp <= '0;
      end else begin
         rsp <= next_rsp;
      end
   end

   assign READ_RSP_OUT = rsp;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_kern_id_trap;
      sel_hit && lvl_kernel && kern_trap;
   endsequence
   sequence s_kern_read;
      sel_hit && lvl_kernel && !kern_trap;
   endsequence
   sequence s_user_to_hyp;
      sel_hit && lvl_user && user_to_hyp;
   endsequence
   sequence s_user_to_kern;
      sel_hit && lvl_user && !user_to_hyp;
   endsequence
   sequence s_hyp_read;
      sel_hit && READ_REQ_IN.current_privilege_level == HYPERVISOR_PRIVILEGE_LEVEL;
   endsequence
   sequence s_monitor_read;
      sel_hit && READ_REQ_IN.current_privilege_level == MONITOR_PRIVILEGE_LEVEL;
   endsequence

   // Field by field; each field gets its own label so a failure names it
   chk_round_mac_field: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL3
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[31:28] == RND_MAC_VALUE)
      else $error("rounding multiply field wrong");
   chk_txmem_field: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL4
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[27:24] == TXMEM_VALUE)
      else $error("transactional memory field wrong");
   chk_atomic_field: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL5
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[23:20] == ATOMIC_VALUE)
      else $error("atomic field wrong");
   chk_checksum_field: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL6
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[19:16] == CHECKSUM_VALUE)
      else $error("checksum field wrong");
   chk_hash_two_field: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL7
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[15:12] == (build_parameter_a_on ? 4'h2 : 4'h0))
      else $error("hash two field wrong");
   chk_hash_one_field: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL8
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[11:8] == (build_parameter_a_on ? 4'h1 : 4'h0))
      else $error("hash one field wrong");
   chk_cipher_field: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL9
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[7:4] == (build_parameter_a_on ? 4'h2 : 4'h0))
      else $error("cipher field wrong");
   chk_reserved_bits: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL14
      READ_RSP_OUT.data[3:0] == 4'h0)
      else $error("reserved bits not zero");
   chk_upper_zero: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL15
      READ_RSP_OUT.data[63:36] == 28'h000_0000)
      else $error("upper bits not zero");

   // Build_parameter_a state: only possible with the build option, taken from the strap
   chk_build_parameter_a_build: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL2
      build_parameter_a_on |-> BUILD_PARAMETER_A)
      else $error("build_parameter_a on without build option");
   chk_strap_capture: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL2
      $rose(rst_n) |-> build_parameter_a_on == (BUILD_PARAMETER_A && !$past(dis_sync)))
      else $error("strap not captured at reset");
   chk_value_fixed: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL15
      s_kern_read |=> READ_RSP_OUT.data == $past(reg_value))
      else $error("read value differs from register");

   // Selector decode
   chk_valid_needed: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL10
      !READ_REQ_IN.valid |=> !READ_RSP_OUT.hit && !READ_RSP_OUT.trap)
      else $error("answer without request");
   chk_miss_quiet: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL10
      (READ_REQ_IN.valid && !sel_hit) |=> READ_RSP_OUT == '0)
      else $error("other register answered");
   chk_op0_code: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL10
      (READ_REQ_IN.valid && READ_REQ_IN.op0 != SEL_OP0) |=> !READ_RSP_OUT.hit)
      else $error("wrong op0 hit");
   chk_op2_code: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL10
      (READ_REQ_IN.valid && READ_REQ_IN.op2 != SEL_OP2) |=> !READ_RSP_OUT.hit)
      else $error("wrong op2 hit");

   // Trap routing
   chk_user_to_hyp: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL11
      s_user_to_hyp |=> READ_RSP_OUT.trap_level == HYPERVISOR_PRIVILEGE_LEVEL)
      else $error("user trap not sent to hypervisor");
   chk_user_to_kernel: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL11
      s_user_to_kern |=> READ_RSP_OUT.trap_level == KERNEL_PRIVILEGE_LEVEL)
      else $error("user trap not sent to kernel");
   chk_trap_no_data: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL11
      READ_RSP_OUT.trap |-> !READ_RSP_OUT.data_valid && READ_RSP_OUT.data == '0)
      else $error("data leaked on trap");
   chk_kernel_class: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL12
      s_kern_id_trap |=> READ_RSP_OUT.trap_class == SYSREG_TRAP_CLASS)
      else $error("kernel trap class wrong");
   chk_kernel_read: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL12
      s_kern_read |=> READ_RSP_OUT.data_valid && !READ_RSP_OUT.trap)
      else $error("kernel read trapped");
   chk_hyp_read: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL13
      s_hyp_read |=> READ_RSP_OUT.data_valid && !READ_RSP_OUT.trap)
      else $error("hypervisor read trapped");
   chk_monitor_read: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL13
      s_monitor_read |=> READ_RSP_OUT.data_valid && !READ_RSP_OUT.trap)
      else $error("monitor read trapped");
   chk_hit_one_kind: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL13
      READ_RSP_OUT.hit |-> READ_RSP_OUT.data_valid != READ_RSP_OUT.trap)
      else $error("hit without exactly one outcome");

   chk_keccak_field: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL1
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[35:32] == (build_parameter_a_on ? 4'h1 : 4'h0))
      else $error("keccak field wrong");
   chk_fixed_fields: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL3
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[31:16] == 16'h1021)
      else $error("fixed fields wrong");
   chk_hash_cipher: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL7
      READ_RSP_OUT.data_valid |-> READ_RSP_OUT.data[15:0] == (build_parameter_a_on ? 16'h2120 : 16'h0000))
      else $error("hash or cipher field wrong");
   chk_strap_frozen: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL15
      $past(rst_n) |-> $stable(build_parameter_a_on))
      else $error("build_parameter_a state changed after reset");
   chk_select_code: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL10
      (READ_REQ_IN.valid && READ_REQ_IN.crm != 4'h6) |=> !READ_RSP_OUT.hit)
      else $error("wrong selector hit");
   chk_user_trap: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL11
      (sel_hit && lvl_user) |=> READ_RSP_OUT.trap && READ_RSP_OUT.trap_class == 6'h18
         && !READ_RSP_OUT.data_valid)
      else $error("user read did not trap");
   chk_kernel_trap: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL12
      s_kern_id_trap |=> READ_RSP_OUT.trap && READ_RSP_OUT.trap_level == 2'h2)
      else $error("kernel id trap missing");
   chk_high_read: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n) // RL13
      (sel_hit && READ_REQ_IN.current_privilege_level[1]) |=> READ_RSP_OUT.data_valid
         && !READ_RSP_OUT.trap)
      else $error("high level read trapped");

endmodule

/* sim/core_model.sv */
module core_model (
   // Clock
   input  wire logic             clk_in,
   // Request toward the register
   output isa_attr_pkg::read_req_t req_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import isa_attr_pkg::*;

   initial req_out = '0;

   // One request per edge, so back-to-back reads are possible; the request on
   // the wire up to this edge is handed back for checking
   task automatic issue(input read_req_t nxt, output read_req_t prev);
      @(posedge clk_in);
      prev = req_out;
      req_out <= nxt;
   endtask
endmodule

/* sim/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import isa_attr_pkg::*;

   localparam bit BUILD_ON = 1'b1;

   logic      clk;
   logic      rst_n;
   logic      build_parameter_a_disable;
   read_req_t req;
   read_rsp_t rsp;
   int        seed;
   int        n_fail;
   int        n_tests;
   int        cyc;

   ////////////////////////////////////////////////////////////////////////////
   // Clock, design and far-side core
   always #20 clk = ~clk;

   isa_feature_id_register #(.BUILD_PARAMETER_A(BUILD_ON)) isa_feature_id_register_i (
      .REF_CLK_IN              (clk),
      .RESET_N_IN              (rst_n),
      .BUILD_PARAMETER_A_DISABLE_INPUT_IN (build_parameter_a_disable),
      .READ_REQ_IN             (req),
      .READ_RSP_OUT            (rsp)
   );

   core_model core_model_i (
      .clk_in  (clk),
      .req_out (req)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Expected answer worked out from the request and the build_parameter_a setting
   function automatic read_rsp_t expect_rsp(input read_req_t q, input bit on);
      read_rsp_t  e;
      logic [1:0] tl;
      logic       tr;
      e = '0;
      e.hit = q.valid && ({q.op0, q.op1, q.crn, q.crm, q.op2} == 16'hC030);
      tl = (q.hyp_enabled && (q.current_privilege_level == 2'h0 ?
            q.hypervisor_general_trap_bit : q.hypervisor_id_trap_bit)) ? 2'h2 : 2'h1;
      tr = (q.current_privilege_level == 2'h0) || (q.current_privilege_level == 2'h1 && tl == 2'h2);
      if (e.hit && tr) begin
         e.trap = 1'b1;
         e.trap_level = tl;
         e.trap_class = 6'h18;
      end else if (e.hit) begin
         e.data_valid = 1'b1;
         e.data = on ? 64'h0000_0001_1021_2120 : 64'h0000_0000_1021_0000;
      end
      return e;
   endfunction

   task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // One reset with the strap at dis, then corner and random reads; the strap
   // is flipped after release to show it is only taken during reset
   task automatic run_phase(input bit dis);
      read_req_t r;
      read_req_t p;
      @(posedge clk);
      rst_n <= 1'b0;
      build_parameter_a_disable <= dis;
      repeat (10) @(posedge clk);
      @(negedge clk);
      chk(80'(rsp), 80'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      build_parameter_a_disable <= ~dis;
      for (int i = 0; i < 232; i++) begin
         r = 22'($random(seed));
         if (i < 32) begin
            r = {1'b1, 16'hC030, i[4:0]};
         end else if (r.crn[3]) begin
            {r.op0, r.op1, r.crn, r.crm, r.op2} = 16'hC030;
         end
         core_model_i.issue(r, p);
         @(negedge clk);
         chk(80'(rsp), 80'(expect_rsp(p, BUILD_ON && !dis)));
      end
      core_model_i.issue('0, p);
      $display("Phase with strap %0d finished", dis);
   endtask

   // Hang guard: two phases take about 496 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         conclude;
      end
   end

   initial begin
      seed = 52573;
      clk = 1'b0;
      rst_n = 1'b0;
      build_parameter_a_disable = 1'b0;
      n_fail = 0;
      n_tests = 0;
      cyc = 0;
      run_phase(1'b0);
      run_phase(1'b1);
      conclude;
   end
endmodule
